// [src/asc_checker.sv]
// Safety checker and test sequencer with AXI4-Lite registers
// Assumes the converter end on the same aclk
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_checker (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output wire logic         awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output wire logic         wready,
  output      logic [1:0]   bresp,
  output      logic         bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output wire logic         arready,
  output      logic [31:0]  rdata,
  output      logic [1:0]   rresp,
  output      logic         rvalid,
  input  wire logic         rready,
  // Interrupt
  output wire logic         irq,
  // Converter link
  asc_link_if.host          lnk
);
  import asc_pkg::*;

  logic [4:1]  ctrl_r;
  logic [31:0] cfg_r, exp_r;
  logic [7:0]  sts_r, mask_r, ev, clr;
  asc_hst_e    st_r;
  logic [1:0]  stp_r, lastp;
  asc_data_t   d_r [3];
  asc_data_t   last_r, exp_ref, cur_d;
  asc_test_e   test;
  logic        trig, cur_adc, legal, wr, start, mapped;
  logic [3:0]  cha, chb, cur_ch;
  logic [31:0] wmask, rd_mux;

  function automatic asc_data_t adiff(asc_data_t a, asc_data_t b);
    return (a > b) ? a - b : b - a;
  endfunction

  assign test    = asc_test_e'(ctrl_r[2:1]);
  assign trig    = ctrl_r[3];
  assign cha     = cfg_r[7:4];
  assign chb     = cfg_r[11:8];
  assign cur_adc = (test == T_DUAL) ? stp_r[0] : cfg_r[0];
  assign cur_ch  = (test == T_DUAL && stp_r[0]) ? chb : cha;
  assign exp_ref = stp_r[0] ? exp_r[25:16] : exp_r[9:0];
  assign cur_d   = d_r[stp_r];
  assign lastp   = (test == T_OPEN) ? (ctrl_r[4] ? 2'h2 : 2'h0)
                 : (test == T_ACQ) ? 2'h2 : 2'h1;
  // double read on 0 to 8
  assign legal = (asc_test_e'(wdata[2:1]) == T_DUAL)
               ? (cha <= `ASC_MAX_NS && chb <= `ASC_MAX_NS)
               : (cha <= `ASC_MAX_NS ||
                  (cha >= `ASC_SH_LO && cha <= `ASC_SH_HI));

  // Register bus
  assign awready = awvalid && wvalid && !bvalid;
  assign wready  = awready;
  assign wr      = awready;
  assign arready = !rvalid;
  for (genvar b = 0; b < 4; b++) begin : g_be
    assign wmask[8*b +: 8] = {8{wstrb[b]}};
  end
  assign start  = wr && awaddr == `ASC_OFF_CTRL && wstrb[0] && wdata[0]
                  && st_r == H_IDLE;
  assign clr    = (wr && awaddr == `ASC_OFF_STS) ? wdata[7:0] & wmask[7:0]
                  : 8'h00;
  assign mapped = (araddr <= `ASC_OFF_INFO) && (araddr[1:0] == 2'h0);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (araddr == `ASC_OFF_CTRL) rd_mux[4:1] = ctrl_r;
    else if (araddr == `ASC_OFF_CFG) rd_mux = cfg_r;
    else if (araddr == `ASC_OFF_STS) rd_mux[7:0] = sts_r;
    else if (araddr == `ASC_OFF_MASK) rd_mux[7:0] = mask_r;
    else if (araddr == `ASC_OFF_EXP) rd_mux = exp_r;
    else if (araddr == `ASC_OFF_LAST) rd_mux[`ASC_DW-1:0] = last_r;
    else if (araddr == `ASC_OFF_INFO) rd_mux[4:0] = {st_r, stp_r};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 4'h0;
      cfg_r  <= `ASC_RST_WORD;
      exp_r  <= `ASC_RST_WORD;
      mask_r <= `ASC_RST_STS;
    end else if (wr) begin
      if (awaddr == `ASC_OFF_CTRL && wstrb[0] && st_r == H_IDLE)
        ctrl_r <= wdata[4:1];
      else if (awaddr == `ASC_OFF_CFG)
        cfg_r <= (cfg_r & ~wmask) | (wdata & wmask);
      else if (awaddr == `ASC_OFF_MASK && wstrb[0])
        mask_r <= wdata[7:0];
      else if (awaddr == `ASC_OFF_EXP)
        exp_r <= (exp_r & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `ASC_RESP_OK;
    end else if (wr) begin
      bvalid <= 1'b1;
      bresp  <= (awaddr <= `ASC_OFF_INFO && awaddr[1:0] == 2'h0)
                ? `ASC_RESP_OK : `ASC_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `ASC_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= mapped ? `ASC_RESP_OK : `ASC_RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Test sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= H_IDLE;
      stp_r <= 2'h0;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (start && legal) begin
            st_r  <= H_SETUP;
            stp_r <= 2'h0;
          end
        end
        H_SETUP: st_r <= H_REQ;
        H_REQ: if (lnk.req_ready) st_r <= H_WAIT;
        H_WAIT: if (lnk.res_valid) st_r <= trig ? H_POP : H_CHECK;
        H_POP: if (lnk.q_valid) st_r <= H_CHECK;
        H_CHECK: begin
          if (stp_r == lastp) begin
            st_r <= H_DONE;
          end else begin
            stp_r <= stp_r + 2'h1;
            st_r  <= H_SETUP;
          end
        end
        H_DONE: st_r <= H_IDLE;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // Converter setup per step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk.presample_enable_bits      <= '0;
      lnk.presample_reference_select <= 2'h0;
      lnk.convert_presampled_select  <= 2'h0;
      lnk.req_adc                    <= 1'b0;
      lnk.req_chan                   <= 4'h0;
      lnk.req_trig                   <= 1'b0;
    end else if (st_r == H_SETUP) begin
      lnk.presample_enable_bits <= '0;
      if (test == T_OPEN || test == T_SHORT)
        lnk.presample_enable_bits[cur_adc][cur_ch] <= 1'b1;
      lnk.presample_reference_select <= {2{~stp_r[0]}};
      lnk.convert_presampled_select  <= {2{test == T_SHORT}};
      lnk.req_adc  <= cur_adc;
      lnk.req_chan <= cur_ch;
      lnk.req_trig <= trig;
    end
  end

  assign lnk.req_valid = (st_r == H_REQ);
  assign lnk.q_ready   = (st_r == H_POP);
  assign lnk.q_sel     = lnk.req_adc;

  // Acquired values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_r <= '0;
    end else if (st_r == H_WAIT && lnk.res_valid) begin
      d_r[stp_r] <= lnk.res_data;
      last_r     <= lnk.res_data;
    end else if (st_r == H_POP && lnk.q_valid) begin
      d_r[stp_r] <= lnk.q_entry.data;
      last_r     <= lnk.q_entry.data;
    end
  end

  // Fault events
  always_comb begin
    ev = 8'h00;
    ev[`ASC_ST_STAT] = st_r == H_WAIT && lnk.res_valid &&
                       (!lnk.res_ok || lnk.res_status != `ASC_RS_OK);
    ev[`ASC_ST_SEQ] = st_r == H_POP && lnk.q_valid &&
                      (lnk.q_entry.chan != cur_ch ||
                       lnk.q_entry.adc != cur_adc);
    ev[`ASC_ST_OPEN] = st_r == H_CHECK && test == T_OPEN &&
                       cur_d == exp_ref;
    ev[`ASC_ST_SHORT] = st_r == H_CHECK && test == T_SHORT &&
                        cur_d != exp_ref;
    ev[`ASC_ST_OVS] = st_r == H_DONE && test == T_ACQ &&
      ((adiff(d_r[0], d_r[1]) > {2'h0, cfg_r[31:24]} &&
        adiff(d_r[0], d_r[2]) > {2'h0, cfg_r[31:24]}) ||
       (adiff(d_r[1], d_r[0]) > {2'h0, cfg_r[31:24]} &&
        adiff(d_r[1], d_r[2]) > {2'h0, cfg_r[31:24]}) ||
       (adiff(d_r[2], d_r[0]) > {2'h0, cfg_r[31:24]} &&
        adiff(d_r[2], d_r[1]) > {2'h0, cfg_r[31:24]}));
    ev[`ASC_ST_RED] = st_r == H_DONE && test == T_DUAL &&
                      adiff(d_r[0], d_r[1]) > {2'h0, cfg_r[23:16]};
    ev[`ASC_ST_DONE] = st_r == H_DONE;
    ev[`ASC_ST_CFG]  = start && !legal;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) sts_r <= `ASC_RST_STS;
    else sts_r <= (sts_r & ~clr) | ev;
  end

  assign irq = |(sts_r & mask_r);
endmodule

// [src/asc_converter.sv]
// Converter control logic of two instances with trigger unit queues
// Assumes pad and reference codes are a digitized analog model
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_converter (
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // Checker link
  asc_link_if.converter                         lnk,
  // Analog front end model
  input  wire logic [1:0][15:0][`ASC_DW-1:0]    pad_value,
  input  wire logic [1:0][15:0]                 pad_input_enable,
  input  wire logic [1:0][`ASC_DW-1:0]          high_reference_supply,
  input  wire logic [1:0][`ASC_DW-1:0]          low_reference_supply
);
  import asc_pkg::*;

  logic [1:0][15:0][`ASC_DW-1:0] pad_s1_r, pad_s2_r;
  logic [1:0][15:0]              pen_s1_r, pen_s2_r;
  logic [1:0][`ASC_DW-1:0]       rhi_s1_r, rhi_s2_r, rlo_s1_r, rlo_s2_r;
  asc_dst_e                      st_r;
  logic [3:0]                    cnt_r;
  logic                          adc_r;
  logic [3:0]                    ch_r;
  logic                          trig_r;
  asc_data_t                     cap_r;
  logic                          chan_ok;
  logic                          last;
  logic [3:0]                    lim;
  logic                          accept;
  logic [1:0]                    q_full, q_empty;
  asc_qent_s                     q_head [2];

  // Front end synchronisers
  always_ff @(posedge aclk) begin
    pad_s1_r <= pad_value;
    pad_s2_r <= pad_s1_r;
    pen_s1_r <= pad_input_enable;
    pen_s2_r <= pen_s1_r;
    rhi_s1_r <= high_reference_supply;
    rhi_s2_r <= rhi_s1_r;
    rlo_s1_r <= low_reference_supply;
    rlo_s2_r <= rlo_s1_r;
  end

  assign chan_ok = (ch_r <= `ASC_MAX_NS) ||
                   (ch_r >= `ASC_SH_LO && ch_r <= `ASC_SH_HI);
  assign lim = (st_r == D_PRES) ? `ASC_PRES_CYC :
               (st_r == D_SAMP) ? `ASC_SAMP_CYC : `ASC_CONV_CYC;
  assign last = (cnt_r == lim - 4'h1);
  assign lnk.req_ready = (st_r == D_IDLE) && !q_full[lnk.req_adc];
  assign accept = lnk.req_valid && lnk.req_ready;

  // Conversion phase sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r  <= D_IDLE;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= (st_r == D_IDLE || st_r == D_DONE || last) ? 4'h0
               : cnt_r + 4'h1;
      case (st_r)
        D_IDLE: begin
          if (accept) begin
            st_r <= lnk.presample_enable_bits[lnk.req_adc][lnk.req_chan]
                    ? D_PRES : D_SAMP;
          end
        end
        D_PRES: begin
          if (last) begin
            st_r <= lnk.convert_presampled_select[adc_r] ? D_CONV : D_SAMP;
          end
        end
        D_SAMP: if (last) st_r <= D_CONV;
        D_CONV: if (last) st_r <= D_DONE;
        D_DONE: st_r <= D_IDLE;
        default: st_r <= D_IDLE;
      endcase
    end
  end

  // Request capture and sampling capacitor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_r  <= 1'b0;
      ch_r   <= 4'h0;
      trig_r <= 1'b0;
      cap_r  <= '0;
    end else if (accept) begin
      adc_r  <= lnk.req_adc;
      ch_r   <= lnk.req_chan;
      trig_r <= lnk.req_trig;
    end else if (st_r == D_PRES) begin
      cap_r <= lnk.presample_reference_select[adc_r] ? rhi_s2_r[adc_r]
               : rlo_s2_r[adc_r];
    end else if (st_r == D_SAMP && pen_s2_r[adc_r][ch_r] && chan_ok) begin
      cap_r <= pad_s2_r[adc_r][ch_r];
    end
  end

  // Result register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk.res_valid  <= 1'b0;
      lnk.res_ok     <= 1'b0;
      lnk.res_status <= `ASC_RS_OK;
      lnk.res_data   <= '0;
    end else begin
      lnk.res_valid <= (st_r == D_CONV) && last;
      if (st_r == D_CONV && last) begin
        lnk.res_ok     <= chan_ok;
        lnk.res_status <= chan_ok ? `ASC_RS_OK : `ASC_RS_BAD;
        lnk.res_data   <= cap_r;
      end
    end
  end

  // Dual trigger unit queue, one per converter
  for (genvar g = 0; g < 2; g++) begin : g_q
    asc_qent_s  mem_r [`ASC_QDEPTH];
    logic [2:0] wp_r, rp_r;
    logic       push, pop;
    assign push = (st_r == D_CONV) && last && trig_r && (adc_r == g);
    assign pop  = lnk.q_ready && (lnk.q_sel == g) && !q_empty[g];
    assign q_full[g]  = (wp_r - rp_r) == 3'h4;
    assign q_empty[g] = (wp_r == rp_r);
    assign q_head[g]  = mem_r[rp_r[1:0]];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wp_r <= 3'h0;
        rp_r <= 3'h0;
      end else begin
        if (push) wp_r <= wp_r + 3'h1;
        if (pop) rp_r <= rp_r + 3'h1;
      end
    end
    always_ff @(posedge aclk) begin
      if (push) mem_r[wp_r[1:0]] <= '{adc: adc_r, chan: ch_r, data: cap_r};
    end
  end

  assign lnk.q_valid = !q_empty[lnk.q_sel];
  assign lnk.q_entry = q_head[lnk.q_sel];
endmodule

// [src/asc_defs.svh]
// Constants of the analog input safety checker
// Assumes inclusion by bare name from package and modules
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_DW        10
`define ASC_QDEPTH    4
`define ASC_PRES_CYC  4'h4
`define ASC_SAMP_CYC  4'h6
`define ASC_CONV_CYC  4'h8
`define ASC_MAX_NS    4'h8
`define ASC_SH_LO     4'hb
`define ASC_SH_HI     4'he
`define ASC_RS_OK     2'h0
`define ASC_RS_BAD    2'h3
`define ASC_OFF_CTRL  8'h00
`define ASC_OFF_CFG   8'h04
`define ASC_OFF_STS   8'h08
`define ASC_OFF_MASK  8'h0c
`define ASC_OFF_EXP   8'h10
`define ASC_OFF_LAST  8'h14
`define ASC_OFF_INFO  8'h18
`define ASC_RST_WORD  32'h0000_0000
`define ASC_RST_STS   8'h00
`define ASC_ST_OPEN   0
`define ASC_ST_SHORT  1
`define ASC_ST_STAT   2
`define ASC_ST_SEQ    3
`define ASC_ST_OVS    4
`define ASC_ST_RED    5
`define ASC_ST_DONE   6
`define ASC_ST_CFG    7
`define ASC_RESP_OK   2'h0
`define ASC_RESP_ERR  2'h2
`endif

// [src/asc_link_if.sv]
// Link between the checker and the converter control logic
// Assumes both ends run on the same aclk
`timescale 1ns/1ps
interface asc_link_if;
  import asc_pkg::*;
  logic [1:0][15:0] presample_enable_bits;
  logic [1:0]       presample_reference_select;
  logic [1:0]       convert_presampled_select;
  logic             req_valid;
  logic             req_ready;
  logic             req_adc;
  logic [3:0]       req_chan;
  logic             req_trig;
  logic             res_valid;
  logic             res_ok;
  logic [1:0]       res_status;
  asc_data_t        res_data;
  logic             q_sel;
  logic             q_valid;
  logic             q_ready;
  asc_qent_s        q_entry;
  modport host (
    output presample_enable_bits, presample_reference_select,
    output convert_presampled_select, req_valid, req_adc, req_chan,
    output req_trig, q_sel, q_ready,
    input  req_ready, res_valid, res_ok, res_status, res_data,
    input  q_valid, q_entry
  );
  modport converter (
    input  presample_enable_bits, presample_reference_select,
    input  convert_presampled_select, req_valid, req_adc, req_chan,
    input  req_trig, q_sel, q_ready,
    output req_ready, res_valid, res_ok, res_status, res_data,
    output q_valid, q_entry
  );
endinterface

// [src/asc_pkg.sv]
// Types shared by both ends of the safety checker link
// Assumes asc_defs.svh on the include path
`include "asc_defs.svh"
package asc_pkg;
  typedef logic [`ASC_DW-1:0] asc_data_t;
  typedef enum logic [1:0] {
    T_OPEN  = 2'h0,
    T_SHORT = 2'h1,
    T_ACQ   = 2'h2,
    T_DUAL  = 2'h3
  } asc_test_e;
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_REQ   = 3'h3,
    H_WAIT  = 3'h2,
    H_POP   = 3'h6,
    H_CHECK = 3'h7,
    H_DONE  = 3'h5
  } asc_hst_e;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_PRES = 3'h1,
    D_SAMP = 3'h3,
    D_CONV = 3'h2,
    D_DONE = 3'h6
  } asc_dst_e;
  typedef struct packed {
    logic      adc;
    logic [3:0] chan;
    asc_data_t data;
  } asc_qent_s;
endpackage

// [tb/asc_link_assertions.sv]
// Concurrent checks on the checker-to-converter link
// Assumes the signals of one asc_link_if, all on aclk
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_link_assertions (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Presampling controls
  input wire logic [1:0][15:0]   presample_enable_bits,
  input wire logic [1:0]         convert_presampled_select,
  // Conversion request
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire logic               req_adc,
  input wire logic [3:0]         req_chan,
  input wire logic               req_trig,
  // Conversion result
  input wire logic               res_valid,
  input wire logic               res_ok,
  input wire logic [1:0]         res_status,
  input wire asc_pkg::asc_data_t res_data,
  // Queue read
  input wire logic               q_valid,
  input wire logic               q_ready,
  input wire asc_pkg::asc_qent_s q_entry
);
  import asc_pkg::*;
  logic take;
  logic pres;
  logic pcs;
  assign take = req_valid && req_ready;
  assign pres = presample_enable_bits[req_adc][req_chan];
  assign pcs  = convert_presampled_select[req_adc];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_convert_presampled_select_latency: assert property (
    take && pres && pcs |-> ##13 res_valid)
    else $error("reference conversion not done after 13 cycles");
  chk_presample_pad: assert property (
    take && pres && !pcs |-> ##19 res_valid)
    else $error("presampled pad conversion not done after 19 cycles");
  chk_plain_latency: assert property (
    take && !pres |-> ##15 res_valid)
    else $error("plain conversion not done after 15 cycles");
  chk_busy_refuse: assert property (
    take |=> (!req_ready && !res_valid) [*8])
    else $error("converter ready or done too early");
  chk_status_flag: assert property (
    res_valid |-> res_ok == (res_status == `ASC_RS_OK))
    else $error("valid flag disagrees with result status");
  chk_queue_push: assert property (
    res_valid && req_trig |=> q_valid)
    else $error("triggered result not queued");
  chk_queue_data: assert property (
    q_valid && q_ready |-> q_entry.data == res_data)
    else $error("queued data differs from result");
  chk_queue_tag: assert property (
    q_valid && q_ready |-> q_entry.chan == req_chan
      && q_entry.adc == req_adc)
    else $error("queued channel tag differs from request");
  chk_req_hold: assert property (
    req_valid |=> $stable(req_chan) && $stable(req_adc))
    else $error("request payload changed during conversion");
endmodule

// [tb/testbench.sv]
// Self-checking bench: checker and converter joined by asc_link_if
// Assumes the AXI4-Lite slave timing of asc_checker
`timescale 1ns/1ps
`include "asc_defs.svh"
module testbench;
  import asc_pkg::*;
  typedef struct packed {
    logic [31:0] cfg;
    logic [7:0]  ctl;
    logic [7:0]  sts;
  } asc_row_s;
  logic                          aclk = 1'b0;
  logic                          aresetn = 1'b0;
  logic [7:0]                    awaddr = 8'h00;
  logic                          awvalid = 1'b0;
  logic                          awready;
  logic [31:0]                   wdata = 32'h0;
  logic [3:0]                    wstrb = 4'hf;
  logic                          wvalid = 1'b0;
  logic                          wready;
  logic [1:0]                    bresp;
  logic                          bvalid;
  logic                          bready = 1'b0;
  logic [7:0]                    araddr = 8'h00;
  logic                          arvalid = 1'b0;
  logic                          arready;
  logic [31:0]                   rdata;
  logic [1:0]                    rresp;
  logic                          rvalid;
  logic                          rready = 1'b0;
  logic                          irq;
  logic [1:0][15:0][`ASC_DW-1:0] pad = {32{10'h155}};
  logic [1:0][15:0]              pen = '1;
  logic [1:0][`ASC_DW-1:0]       hi = {2{10'h3f0}};
  logic [1:0][`ASC_DW-1:0]       lo = {2{10'h010}};
  logic [31:0]                   d;
  logic [1:0]                    r;
  int                            fails = 0;
  int                            num_checks = 0;
  asc_row_s rows [9] = '{
    '{32'h0804_0320, 8'h01, 8'h40},
    '{32'h0804_0320, 8'h03, 8'h40},
    '{32'h0804_0320, 8'h05, 8'h40},
    '{32'h0804_0320, 8'h07, 8'h40},
    '{32'h0804_0320, 8'h0d, 8'h40},
    '{32'h0804_0320, 8'h11, 8'h40},
    '{32'h0804_03c0, 8'h05, 8'h40},
    '{32'h0804_03c0, 8'h07, 8'h80},
    '{32'h0804_0390, 8'h05, 8'h80}
  };
  asc_link_if lnk ();
  asc_checker u_asc_checker (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .lnk(lnk)
  );
  asc_converter u_asc_converter (
    .aclk(aclk), .aresetn(aresetn), .lnk(lnk), .pad_value(pad),
    .pad_input_enable(pen), .high_reference_supply(hi),
    .low_reference_supply(lo)
  );
  asc_link_assertions u_asc_link_assertions (
    .aclk(aclk), .aresetn(aresetn),
    .presample_enable_bits(lnk.presample_enable_bits),
    .convert_presampled_select(lnk.convert_presampled_select),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
    .req_adc(lnk.req_adc), .req_chan(lnk.req_chan),
    .req_trig(lnk.req_trig), .res_valid(lnk.res_valid),
    .res_ok(lnk.res_ok), .res_status(lnk.res_status),
    .res_data(lnk.res_data), .q_valid(lnk.q_valid),
    .q_ready(lnk.q_ready), .q_entry(lnk.q_entry)
  );
  always #4 aclk = ~aclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic run(input asc_row_s w);
    wr(`ASC_OFF_CFG, w.cfg);
    wr(`ASC_OFF_CTRL, {24'h0, w.ctl});
    do rd(`ASC_OFF_STS); while (d[7:6] === 2'h0);
    check(d, {24'h0, w.sts});
  endtask
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    results();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ASC_OFF_STS);
    check(d, `ASC_RST_WORD);
    rd(8'h1c);
    check({r, d[29:0]}, {`ASC_RESP_ERR, 30'h0});
    wr(8'h1c, 32'hffff_ffff);
    check({30'h0, r}, {30'h0, `ASC_RESP_ERR});
    wr(`ASC_OFF_MASK, 32'hff);
    wr(`ASC_OFF_EXP, 32'h0010_03f0);
    foreach (rows[i]) begin
      run(rows[i]);
      check({31'h0, irq}, 32'h1);
      wr(`ASC_OFF_STS, 32'hff);
      check({31'h0, irq}, 32'h0);
    end
    // Disabled pad path seen as open
    pen[0][2] <= 1'b0;
    run('{32'h0804_0320, 8'h01, 8'h41});
    wr(`ASC_OFF_STS, 32'h40);
    rd(`ASC_OFF_STS);
    check(d, 32'h01);
    wr(`ASC_OFF_MASK, 32'h00);
    check({31'h0, irq}, 32'h0);
    wr(`ASC_OFF_MASK, 32'h01);
    check({31'h0, irq}, 32'h1);
    wr(`ASC_OFF_STS, 32'hff);
    check({31'h0, irq}, 32'h0);
    pen[0][2] <= 1'b1;
    // Wrong expected high reference
    wr(`ASC_OFF_EXP, 32'h0010_03e0);
    run('{32'h0804_0320, 8'h03, 8'h42});
    wr(`ASC_OFF_STS, 32'hff);
    wr(`ASC_OFF_EXP, 32'h0010_03f0);
    // Redundant copy at tolerance, then beyond it
    pad[1][3] <= 10'h159;
    run('{32'h0804_0320, 8'h07, 8'h40});
    wr(`ASC_OFF_STS, 32'hff);
    pad[1][3] <= 10'h175;
    run('{32'h0804_0320, 8'h07, 8'h60});
    wr(`ASC_OFF_STS, 32'hff);
    // Third of three conversions deviating
    wr(`ASC_OFF_CTRL, 32'h0000_0005);
    repeat (29) @(posedge aclk);
    pad[0][2] <= 10'h1a0;
    do rd(`ASC_OFF_STS); while (d[7:6] === 2'h0);
    check(d, 32'h50);
    results();
  end
endmodule
